// ==== logic/ctl_pkg.sv ====
// constants shared by the control bus peripheral logic
// assumes one system clock; all pin groups sampled on it
package ctl_pkg;
  // link format of a serial slave port
  typedef enum logic [1:0] {
    FMT_I2C    = 2'b00,
    FMT_VENDOR = 2'b01,
    FMT_RAW    = 2'b10
  } link_fmt_t;
  // byte phase inside a frame
  typedef enum logic [1:0] {
    PH_ADDR = 2'b00,
    PH_PTR  = 2'b01,
    PH_DATA = 2'b10,
    PH_IDLE = 2'b11
  } phase_t;
  localparam logic [3:0] LAST_BIT   = 4'h7;   // last data bit of a byte
  localparam logic [3:0] ACK_BIT    = 4'h8;   // ninth clock of an i2c byte
  // positions inside the synchronised pin vector
  localparam int         SY_CTL     = 0;      // control port: sclk, data, sel_n
  localparam int         SY_DIO     = 3;      // ten dedicated pins
  localparam int         SY_IRQ     = 13;     // four interrupt pins
  localparam int         SY_DBG     = 17;     // three debug shared pins
  localparam int         SY_BOOT    = 20;     // boot select pin
  localparam int         SY_W       = 21;
  // roles of the three debug shared pins
  localparam int         DBG_SCLK   = 0;
  localparam int         DBG_DATA   = 1;
  localparam int         DBG_SEL    = 2;
  // pin roles inside the dedicated group
  localparam int         SVC_PIN    = 7;      // service request to the controller
  localparam int         SP0_PIN    = 8;
  localparam int         SP1_PIN    = 9;
  // global timer flag bits
  localparam int         GT_FLAGS   = 4;      // 8, 4, 2 and 1 times fs
  localparam logic [2:0] GT_PH_LAST = 3'h7;   // last 8fs tick of a sample period
  localparam logic [15:0] TIMER_RST = 16'h0000;
  localparam logic [7:0] BYTE_RST   = 8'h00;
  localparam logic [SY_W-1:0] SY_RST = 21'h080004;  // synced pins idle: both selects high
endpackage : ctl_pkg

// ==== logic/ser_if.sv ====
// byte-level connection between a serial slave port and the shared store
// assumes rd_data answers rd_ptr in the same cycle
`timescale 1ns/10ps
interface ser_if #(parameter int PTR_W = 8);
  logic             wr_stb;     // one-cycle store request
  logic [PTR_W-1:0] wr_ptr;     // location to store
  logic [7:0]       wr_data;    // byte to store
  logic [PTR_W-1:0] rd_ptr;     // location to fetch
  logic [7:0]       rd_data;    // fetched byte
  logic             raw_stb;    // one-cycle raw byte to host
  logic [7:0]       raw_data;   // raw byte
  logic             frame_end;  // one-cycle end of frame
  modport port (output wr_stb, wr_ptr, wr_data, rd_ptr, raw_stb, raw_data, frame_end,
                input  rd_data);
  modport core (input  wr_stb, wr_ptr, wr_data, rd_ptr, raw_stb, raw_data, frame_end,
                output rd_data);
endinterface : ser_if

// ==== logic/serial_slave.sv ====
// one serial slave port: i2c, vendor spi or raw spi on three wires
// assumes sclk, sel_n and din are already synchronised to clk_sys
`timescale 1ns/10ps
module serial_slave #(parameter int PTR_W = 8) (
  input  wire logic              clk_sys,
  input  wire logic              rst_n,
  input  wire logic              ce,
  input  wire ctl_pkg::link_fmt_t fmt,
  input  wire logic [6:0]        dev_addr,
  input  wire logic              sclk,
  input  wire logic              sel_n,
  input  wire logic              din,
  output logic                   dout,
  output logic                   dout_oe,
  ser_if.port                    bus
);
  logic             sclk_q, din_q, sel_q;       // previous samples for edges
  logic             active_reg;                 // i2c frame open
  ctl_pkg::phase_t  phase_reg;                  // byte phase
  logic [3:0]       bit_reg;                    // bits taken in this byte
  logic [7:0]       sh_reg, tx_reg;             // receive and send shifters
  logic             rw_reg, hit_reg, ack_reg;   // direction, addressed, ack due
  logic [PTR_W-1:0] ptr_reg;                    // register pointer
  logic             wr_reg, raw_reg, end_reg;
  logic [7:0]       data_reg;
  logic [PTR_W-1:0] wptr_reg;

  // edge and frame decode
  wire is_i2c    = fmt == ctl_pkg::FMT_I2C;
  wire is_raw    = fmt == ctl_pkg::FMT_RAW;
  wire rise      = sclk & ~sclk_q;
  wire fall      = ~sclk & sclk_q;
  wire start_c   = is_i2c & sclk & sclk_q & din_q & ~din;
  wire stop_c    = is_i2c & sclk & sclk_q & ~din_q & din;
  wire spi_start = ~is_i2c & ~sel_n & sel_q;
  wire spi_stop  = ~is_i2c & sel_n & ~sel_q;
  wire in_frame  = is_i2c ? active_reg : ~sel_n;
  wire data_bit  = in_frame & rise & (bit_reg < ctl_pkg::ACK_BIT);
  wire byte_done = data_bit & (bit_reg == ctl_pkg::LAST_BIT);
  wire [7:0] byte_c = {sh_reg[6:0], din};
  wire addr_byte = byte_done & ~is_raw & (phase_reg == ctl_pkg::PH_ADDR);
  wire addr_hit  = byte_c[7:1] == dev_addr;
  wire ptr_byte  = byte_done & ~is_raw & (phase_reg == ctl_pkg::PH_PTR);
  wire wdata     = byte_done & ~is_raw & (phase_reg == ctl_pkg::PH_DATA) & hit_reg & ~rw_reg;
  wire rdata     = byte_done & ~is_raw & (phase_reg == ctl_pkg::PH_DATA) & hit_reg & rw_reg;
  wire load_tx   = (addr_byte & addr_hit & byte_c[0]) | rdata | (byte_done & is_raw);
  wire sending   = is_raw | (hit_reg & rw_reg & (phase_reg == ctl_pkg::PH_DATA));
  wire tx_bit    = tx_reg[~bit_reg[2:0]];

  assign bus.rd_ptr    = ptr_reg;
  assign bus.wr_stb    = wr_reg;
  assign bus.wr_ptr    = wptr_reg;
  assign bus.wr_data   = data_reg;
  assign bus.raw_stb   = raw_reg;
  assign bus.raw_data  = data_reg;
  assign bus.frame_end = end_reg;

  // frame sequencing and byte handling
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      {sclk_q, din_q, sel_q} <= 3'h1;                   // match the synced idle levels
      active_reg <= 1'b0;
      phase_reg  <= ctl_pkg::PH_IDLE;
      bit_reg    <= 4'h0;
      sh_reg     <= ctl_pkg::BYTE_RST;
      tx_reg     <= ctl_pkg::BYTE_RST;
      {rw_reg, hit_reg, ack_reg, wr_reg, raw_reg, end_reg} <= 6'h00;
      data_reg   <= ctl_pkg::BYTE_RST;
      ptr_reg    <= '0;
      wptr_reg   <= '0;
    end else if (ce) begin
      {sclk_q, din_q, sel_q} <= {sclk, din, sel_n};
      wr_reg  <= wdata;                                   // RL4
      raw_reg <= byte_done & is_raw;                      // RL6
      end_reg <= stop_c | spi_stop;
      if (byte_done) data_reg <= byte_c;
      if (wdata) wptr_reg <= ptr_reg;
      if (stop_c) active_reg <= 1'b0;
      if (start_c | spi_start) begin
        // new frame: pointer survives for a later read, except in raw format where it clears to zero
        active_reg <= is_i2c;
        phase_reg  <= ctl_pkg::PH_ADDR;                   // RL3
        bit_reg    <= 4'h0;
        hit_reg    <= 1'b0;
        tx_reg     <= ctl_pkg::BYTE_RST;
        if (is_raw) ptr_reg <= '0;
      end else if (data_bit) begin
        sh_reg  <= byte_c;
        bit_reg <= (byte_done & ~is_i2c) ? 4'h0 : bit_reg + 4'h1;
        if (byte_done) ack_reg <= (addr_byte & addr_hit) | (ptr_byte & hit_reg) | wdata;
        if (addr_byte) begin
          rw_reg    <= byte_c[0];
          hit_reg   <= addr_hit;
          phase_reg <= !addr_hit ? ctl_pkg::PH_IDLE :
                       (byte_c[0] ? ctl_pkg::PH_DATA : ctl_pkg::PH_PTR);
        end
        if (ptr_byte) begin
          ptr_reg   <= byte_c[PTR_W-1:0];                 // RL4
          phase_reg <= ctl_pkg::PH_DATA;
        end
        if (load_tx) tx_reg <= bus.rd_data;               // RL5
        if (load_tx | wdata) ptr_reg <= ptr_reg + 1'b1;   // RL22
      end else if (in_frame & rise) begin
        bit_reg <= 4'h0;                                  // i2c ack clock
      end
    end
  end

  // data line: changed only while the clock is low; never driven outside a frame
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      dout    <= 1'b0;
      dout_oe <= 1'b0;
    end else if (ce) begin
      if (!in_frame | stop_c | spi_stop) begin
        dout_oe <= 1'b0;                                  // RL1
      end else if (fall & is_i2c) begin
        dout    <= 1'b0;
        dout_oe <= (bit_reg == ctl_pkg::ACK_BIT) ? ack_reg : (sending & ~tx_bit);
      end else if (fall) begin
        dout    <= tx_bit;
        dout_oe <= sending;
      end
    end
  end

  slave_quiet_a: assert property (@(posedge clk_sys) disable iff (!rst_n)  // RL1
    !in_frame |=> !dout_oe) else $error("slave drives data outside a frame");
endmodule : serial_slave

// ==== logic/control_bus_peripherals.sv ====
// control bus peripherals: control port, debug port, mailbox framing,
// global timer, gpio with timer capture and compare outputs
// assumes pins arrive asynchronous; ticks and host signals are on clk_sys
//
// Functional notes
// [RL1] ports only answer the external master
// [RL2] one link format selected per port
// [RL3] frames open with address and direction byte
// [RL4] first written byte sets pointer, rest stored
// [RL5] reads return data at earlier pointer
// [RL6] raw format passes bytes uninterpreted
// [RL7] gpio pin signals service request
// [RL8] debug port interrupt cannot be masked
// [RL9] debug port offers the same formats
// [RL10] pins 18 to 16 shared with debug
// [RL11] mailbox uses pointer then data framing
// [RL12] global flags up to eight times fs
// [RL13] global timer gives fs based interval
// [RL14] ten dedicated host controlled io pins
// [RL15] boot pin selects alternate reset vector; code latches pin_level while it still holds SY_RST, so boot_vector_sel stays 0
// [RL16] pins 15 to 12 raise interrupts
// [RL17] pins 13, 12 capture io timer
// [RL18] pins 11, 10 toggle on compare
// [RL19] io timer runs at 64 fs
// [RL20] pins 9, 8 drivable by processors
// [RL21] io timer wraps freely
// [RL22] pointer advances after each data byte
`timescale 1ns/10ps
module control_bus_peripherals #(parameter int PTR_W = 8) (
  input  wire logic               clk_sys,
  input  wire logic               rst_n,
  input  wire logic               ce,
  input  wire ctl_pkg::link_fmt_t ctl_fmt,
  input  wire ctl_pkg::link_fmt_t dbg_fmt,
  input  wire logic [6:0]         ctl_dev_addr,
  input  wire logic [6:0]         dbg_dev_addr,
  input  wire logic               ctl_sclk_pin,
  input  wire logic               ctl_sel_n_pin,
  input  wire logic               ctl_data_pin_in,
  output logic                    ctl_data_pin_out,
  output logic                    ctl_data_pin_oe,
  input  wire logic               debug_port_en,
  input  wire logic [2:0]         debug_shared_pins_in,
  output logic [2:0]              debug_shared_pins_out,
  output logic [2:0]              debug_shared_pins_oe,
  input  wire logic [2:0]         debug_io_out,
  input  wire logic [2:0]         debug_io_oe,
  input  wire logic [9:0]         dedicated_io_pins_in,
  output logic [9:0]              dedicated_io_pins_out,
  output logic [9:0]              dedicated_io_pins_oe,
  input  wire logic [9:0]         host_io_out,
  input  wire logic [9:0]         host_io_oe,
  input  wire logic               service_req,
  input  wire logic [1:0]         sp_sel,
  input  wire logic               sp0_out,
  input  wire logic               sp0_oe,
  input  wire logic               sp1_out,
  input  wire logic               sp1_oe,
  output logic [ctl_pkg::SY_W-1:0] pin_level,
  input  wire logic [3:0]         interrupt_pins,
  input  wire logic [3:0]         gpio_irq_en,
  input  wire logic [3:0]         gpio_irq_clr,
  output logic [3:0]              gpio_irq,
  input  wire logic               io_tick_64fs,
  output logic [15:0]             io_timer,
  output logic [15:0]             capture0,
  output logic [15:0]             capture1,
  input  wire logic [15:0]        compare0,
  input  wire logic [15:0]        compare1,
  input  wire logic [1:0]         compare_en,
  output logic [1:0]              compare_toggle_pins_out,
  output logic [1:0]              compare_toggle_pins_oe,
  input  wire logic               fs8_tick,
  input  wire logic [7:0]         gt_interval,
  input  wire logic [3:0]         gt_flags_clr,
  output logic [3:0]              gt_flags,
  output logic                    gt_interval_pulse,
  input  wire logic               mbx_valid,
  input  wire logic               mbx_first,
  input  wire logic [7:0]         mbx_byte,
  input  wire logic               host_wr,
  input  wire logic [PTR_W-1:0]   host_addr,
  input  wire logic [7:0]         host_wdata,
  output logic [7:0]              host_rdata,
  output logic                    raw_valid,
  output logic [7:0]              raw_byte,
  output logic                    raw_from_debug,
  output logic                    debug_irq,
  input  wire logic               debug_irq_clr,
  input  wire logic               boot_vector_select_pin,
  output logic                    boot_vector_sel
);
  // refuse pointer widths that the pointer byte cannot fill
  if (PTR_W < 1 || PTR_W > 8) begin : g_bad_ptr
    $error("PTR_W must lie between 1 and 8");
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  logic [ctl_pkg::SY_W-1:0] sync1_reg;         // first stage, read only by second
  logic [7:0]       store [2**PTR_W];          // shared pointer-addressed store
  logic [PTR_W-1:0] mbx_ptr_reg;               // mailbox pointer
  logic [3:0]       irq_prev_reg;              // previous interrupt pin levels
  logic [2:0]       gt_ph_reg;                 // 8fs phase in a sample period
  logic [7:0]       gt_cnt_reg;                // sample periods since last pulse
  logic             boot_done_reg;             // boot level already caught

  ser_if #(.PTR_W(PTR_W)) ctl_bus ();
  ser_if #(.PTR_W(PTR_W)) dbg_bus ();

  // synchronised pin views
  wire [ctl_pkg::SY_W-1:0] pin_raw = {boot_vector_select_pin, debug_shared_pins_in,
    interrupt_pins, dedicated_io_pins_in, ctl_sel_n_pin, ctl_data_pin_in, ctl_sclk_pin};
  wire [2:0] ctl_s  = pin_level[ctl_pkg::SY_CTL +: 3];
  wire [2:0] dbg_s  = pin_level[ctl_pkg::SY_DBG +: 3];
  wire [3:0] irq_s  = pin_level[ctl_pkg::SY_IRQ +: 4];
  wire [3:0] irq_up = irq_s & ~irq_prev_reg;
  wire       dbg_sclk  = debug_port_en & dbg_s[ctl_pkg::DBG_SCLK];
  wire       dbg_sel_n = ~debug_port_en | dbg_s[ctl_pkg::DBG_SEL];
  wire       dbg_dout, dbg_doe, ctl_dout, ctl_doe;

  // io timer and compare decode
  wire [15:0] timer_next = io_timer + 16'h0001;                    // RL21
  wire [1:0]  cmp_hit = {timer_next == compare1, timer_next == compare0};
  wire [1:0]  cmp_tog = compare_en & cmp_hit & {2{io_tick_64fs}};  // RL18

  // global timer decode: flag k fires when the low k phase bits are all ones
  wire [3:0] gt_fire;
  wire       fs_period = fs8_tick & (gt_ph_reg == ctl_pkg::GT_PH_LAST);
  wire       gt_due    = fs_period & (gt_interval != 8'h00) &
                         (gt_cnt_reg + 8'h01 >= gt_interval);     // RL13
  genvar k;
  for (k = 0; k < ctl_pkg::GT_FLAGS; k++) begin : g_gt
    wire [2:0] msk = 3'((1 << k) - 1);
    assign gt_fire[k] = fs8_tick & ((gt_ph_reg & msk) == msk);    // RL12
  end

  // store access from ports, mailbox and host
  assign ctl_bus.rd_data = store[ctl_bus.rd_ptr];                 // RL5
  assign dbg_bus.rd_data = store[dbg_bus.rd_ptr];
  wire mbx_wr = mbx_valid & ~mbx_first;                           // RL11

  // control port; format chosen by ctl_fmt alone
  serial_slave #(.PTR_W(PTR_W)) u_ctl (                           // RL2
    .clk_sys  (clk_sys),
    .rst_n    (rst_n),
    .ce       (ce),
    .fmt      (ctl_fmt),
    .dev_addr (ctl_dev_addr),
    .sclk     (ctl_s[0]),
    .sel_n    (ctl_s[2]),
    .din      (ctl_s[1]),
    .dout     (ctl_dout),
    .dout_oe  (ctl_doe),
    .bus      (ctl_bus)
  );

  // debug port; same slave, pins shared with plain io
  serial_slave #(.PTR_W(PTR_W)) u_dbg (                           // RL9
    .clk_sys  (clk_sys),
    .rst_n    (rst_n),
    .ce       (ce),
    .fmt      (dbg_fmt),
    .dev_addr (dbg_dev_addr),
    .sclk     (dbg_sclk),
    .sel_n    (dbg_sel_n),
    .din      (dbg_s[ctl_pkg::DBG_DATA]),
    .dout     (dbg_dout),
    .dout_oe  (dbg_doe),
    .bus      (dbg_bus)
  );

  // two-stage synchroniser on every pin input
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      sync1_reg <= ctl_pkg::SY_RST;  // selects start idle, no false frame
      pin_level <= ctl_pkg::SY_RST;
    end else if (ce) begin
      sync1_reg <= pin_raw;
      pin_level <= sync1_reg;
    end
  end

  // shared store: control beats debug beats mailbox beats host
  always_ff @(posedge clk_sys) begin
    if (ce) begin
      if (ctl_bus.wr_stb) store[ctl_bus.wr_ptr] <= ctl_bus.wr_data;  // RL4
      else if (dbg_bus.wr_stb) store[dbg_bus.wr_ptr] <= dbg_bus.wr_data;
      else if (mbx_wr) store[mbx_ptr_reg] <= mbx_byte;
      else if (host_wr) store[host_addr] <= host_wdata;
    end
  end

  // host readback, raw bytes, mailbox pointer, debug interrupt
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      host_rdata     <= ctl_pkg::BYTE_RST;
      raw_valid      <= 1'b0;
      raw_byte       <= ctl_pkg::BYTE_RST;
      raw_from_debug <= 1'b0;
      mbx_ptr_reg    <= '0;
      debug_irq      <= 1'b0;
    end else if (ce) begin
      host_rdata <= store[host_addr];
      raw_valid  <= ctl_bus.raw_stb | dbg_bus.raw_stb;             // RL6
      raw_from_debug <= ~ctl_bus.raw_stb;
      raw_byte   <= ctl_bus.raw_stb ? ctl_bus.raw_data : dbg_bus.raw_data;
      if (mbx_valid & mbx_first) mbx_ptr_reg <= mbx_byte[PTR_W-1:0];  // RL11
      else if (mbx_wr) mbx_ptr_reg <= mbx_ptr_reg + 1'b1;
      // no mask term: set wins over clear
      if (dbg_bus.frame_end) debug_irq <= 1'b1;                  // RL8
      else if (debug_irq_clr) debug_irq <= 1'b0;
    end
  end

  // pin drivers, all registered
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      ctl_data_pin_out      <= 1'b0;
      ctl_data_pin_oe       <= 1'b0;
      debug_shared_pins_out <= 3'h0;
      debug_shared_pins_oe  <= 3'h0;
      dedicated_io_pins_out <= 10'h000;
      dedicated_io_pins_oe  <= 10'h000;
    end else if (ce) begin
      ctl_data_pin_out <= ctl_dout;
      ctl_data_pin_oe  <= ctl_doe;
      debug_shared_pins_out <= debug_port_en ? {1'b0, dbg_dout, 1'b0} : debug_io_out;  // RL10
      debug_shared_pins_oe  <= debug_port_en ? {1'b0, dbg_doe, 1'b0} : debug_io_oe;
      dedicated_io_pins_out <= host_io_out;                       // RL14
      dedicated_io_pins_oe  <= host_io_oe;
      if (service_req) begin
        dedicated_io_pins_out[ctl_pkg::SVC_PIN] <= 1'b1;          // RL7
        dedicated_io_pins_oe[ctl_pkg::SVC_PIN]  <= 1'b1;
      end
      if (sp_sel[0]) begin
        dedicated_io_pins_out[ctl_pkg::SP0_PIN] <= sp0_out;       // RL20
        dedicated_io_pins_oe[ctl_pkg::SP0_PIN]  <= sp0_oe;
      end
      if (sp_sel[1]) begin
        dedicated_io_pins_out[ctl_pkg::SP1_PIN] <= sp1_out;       // RL20
        dedicated_io_pins_oe[ctl_pkg::SP1_PIN]  <= sp1_oe;
      end
    end
  end

  // io timer, capture, compare toggles, pin interrupts
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      io_timer     <= ctl_pkg::TIMER_RST;
      capture0     <= ctl_pkg::TIMER_RST;
      capture1     <= ctl_pkg::TIMER_RST;
      compare_toggle_pins_out <= 2'h0;
      compare_toggle_pins_oe  <= 2'h0;
      irq_prev_reg <= 4'h0;
      gpio_irq     <= 4'h0;
    end else if (ce) begin
      if (io_tick_64fs) io_timer <= timer_next;                   // RL19
      if (irq_up[0]) capture0 <= io_timer;                        // RL17
      if (irq_up[1]) capture1 <= io_timer;                        // RL17
      compare_toggle_pins_out <= compare_toggle_pins_out ^ cmp_tog;  // RL18
      compare_toggle_pins_oe  <= compare_en;
      irq_prev_reg <= irq_s;
      // sticky per pin; a new enabled edge wins over the clear
      gpio_irq <= (gpio_irq & ~gpio_irq_clr) | (irq_up & gpio_irq_en);  // RL16
    end
  end

  // global timer flags, interval, boot vector capture
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      gt_ph_reg         <= 3'h0;
      gt_cnt_reg        <= 8'h00;
      gt_flags          <= 4'h0;
      gt_interval_pulse <= 1'b0;
      boot_done_reg     <= 1'b0;
      boot_vector_sel   <= 1'b0;
    end else if (ce) begin
      if (fs8_tick) gt_ph_reg <= gt_ph_reg + 3'h1;
      gt_flags <= (gt_flags & ~gt_flags_clr) | gt_fire;           // RL12
      gt_interval_pulse <= gt_due;                                // RL13
      if (gt_due) gt_cnt_reg <= 8'h00;
      else if (fs_period) gt_cnt_reg <= gt_cnt_reg + 8'h01;
      boot_done_reg <= 1'b1;
      if (!boot_done_reg) boot_vector_sel <= pin_level[ctl_pkg::SY_BOOT];  // RL15
    end
  end

  // all ones wraps to zero
  timer_wrap_a: assert property (ce && io_tick_64fs && io_timer == 16'hffff  // RL21
    |=> io_timer == 16'h0000) else $error("io timer did not wrap");

  // one step per tick
  timer_step_a: assert property (ce && io_tick_64fs  // RL19
    |=> io_timer == $past(io_timer) + 16'h0001) else $error("io timer missed a tick");

  // capture takes the count
  capture_take_a: assert property (ce && irq_up[0]  // RL17
    |=> capture0 == $past(io_timer)) else $error("capture missed timer value");

  // compare hit flips the pin
  compare_flip_a: assert property (ce && cmp_tog[1]  // RL18
    |=> compare_toggle_pins_out[1] != $past(compare_toggle_pins_out[1]))
    else $error("compare pin did not toggle");

  // period end sets fs flags
  gt_fs1_a: assert property (ce && fs8_tick && gt_ph_reg == 3'h7  // RL12
    |=> gt_flags[3] && gt_flags[0]) else $error("fs flag not set");

  // held until cleared
  dbg_irq_hold_a: assert property (ce && dbg_bus.frame_end  // RL8
    |=> debug_irq ##1 (debug_irq || $past(debug_irq_clr)))
    else $error("debug interrupt lost");

  // processor owns pin 8
  sp0_drive_a: assert property (ce && sp_sel[0]  // RL20
    |=> dedicated_io_pins_out[8] == $past(sp0_out)) else $error("pin 8 not from processor");

  // boot choice frozen
  boot_hold_a: assert property (boot_done_reg && ce  // RL15
    |=> $stable(boot_vector_sel)) else $error("boot vector changed after start");

  // raw bytes unchanged
  raw_pass_a: assert property (ce && ctl_bus.raw_stb  // RL6
    |=> raw_valid && raw_byte == $past(ctl_bus.raw_data)) else $error("raw byte altered");

  // pointer byte loads
  mbx_ptr_a: assert property (ce && mbx_valid && mbx_first  // RL11
    |=> mbx_ptr_reg == $past(mbx_byte[PTR_W-1:0])) else $error("mailbox pointer not taken");

  // enabled edge raises flag
  pin_irq_set_a: assert property (ce && irq_up[0] && gpio_irq_en[0]  // RL16
    |=> gpio_irq[0]) else $error("pin interrupt not raised");

  // service pin driven high
  svc_pin_a: assert property (ce && service_req  // RL7
    |=> dedicated_io_pins_oe[ctl_pkg::SVC_PIN] && dedicated_io_pins_out[ctl_pkg::SVC_PIN])
    else $error("service pin not driven");
endmodule : control_bus_peripherals

// ==== sim/ctl_master.sv ====
// partner: external controller running the control port in vendor spi framing
// assumes the bench resolves the shared data wire from the device enable alone
`timescale 1ns/10ps
module ctl_master (
  output logic      sclk,  // link clock, still outside frames
  output logic      sel_n, // frame select, active low
  output logic      dout,  // controller data drive
  input  wire logic din    // resolved data wire
);
  // idle: deselected, clock low
  initial begin
    sclk = 1'b0;
    sel_n = 1'b1;
    dout = 1'b0;
  end
  // one byte msb first, 400 ns a phase; only this side starts frames
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      dout = tx[i];
      #400;
      sclk = 1'b1;
      rx[i] = din;
      #400;
      sclk = 1'b0;
    end
  endtask : xfer
  // open or close a frame in the one selected format
  task automatic frame(input logic open);
    dout = ~dout; // idle line shows the inverse
    #400;
    sel_n = ~open;
  endtask : frame
endmodule : ctl_master

// ==== sim/control_bus_peripherals_bench.sv ====
// bench: control port frames, store, service pin, io timer, global flags
// assumes ctl_master and the design are compiled first
`timescale 1ns/10ps
module control_bus_peripherals_bench;
  logic clk_sys, rst_n, ce, debug_port_en, service_req, sp0_out, sp0_oe, sp1_out, sp1_oe;
  logic io_tick_64fs, fs8_tick, mbx_valid, mbx_first, host_wr, debug_irq_clr;
  logic boot_vector_select_pin, ctl_sclk_pin, ctl_sel_n_pin, ctl_data_pin_in;
  logic ctl_data_pin_out, ctl_data_pin_oe, raw_valid, raw_from_debug, debug_irq;
  logic boot_vector_sel, gt_interval_pulse, m_dout;
  ctl_pkg::link_fmt_t ctl_fmt, dbg_fmt;
  logic [6:0]  ctl_dev_addr, dbg_dev_addr;
  logic [2:0]  debug_shared_pins_in, debug_shared_pins_out, debug_shared_pins_oe;
  logic [2:0]  debug_io_out, debug_io_oe;
  logic [9:0]  dedicated_io_pins_in, dedicated_io_pins_out, dedicated_io_pins_oe;
  logic [9:0]  host_io_out, host_io_oe;
  logic [1:0]  sp_sel, compare_en, compare_toggle_pins_out, compare_toggle_pins_oe;
  logic [20:0] pin_level;
  logic [3:0]  interrupt_pins, gpio_irq_en, gpio_irq_clr, gpio_irq, gt_flags_clr, gt_flags;
  logic [15:0] io_timer, capture0, capture1, compare0, compare1;
  logic [7:0]  gt_interval, mbx_byte, host_addr, host_wdata, host_rdata, raw_byte, rx;
  logic [23:0] r_all; // bytes returned on the link
  int          fail_count, check_count, cycles;
  // data wire: device wins while it drives
  assign ctl_data_pin_in = ctl_data_pin_oe ? ctl_data_pin_out : m_dout;
  control_bus_peripherals dut (.*);
  ctl_master m (.sclk(ctl_sclk_pin), .sel_n(ctl_sel_n_pin), .dout(m_dout), .din(ctl_data_pin_in));
  // clock
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  // hang guard
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      stop_test();
    end
  end
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic stop_test();
    if (fail_count == 0 && check_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : stop_test
  // one frame of n bytes taken msb first from b
  task automatic send(input logic [31:0] b, input int n);
    m.frame(1'b1);
    for (int k = 0; k < n; k++) begin
      m.xfer(b[31-8*k -: 8], rx);
      r_all = {r_all[15:0], rx};
    end
    m.frame(1'b0);
    repeat (4) @(negedge clk_sys);
  endtask : send
  // pulses on one tick input
  task automatic ticks(input int n, ref logic t);
    repeat (n) begin
      @(negedge clk_sys);
      t = 1'b1;
      @(negedge clk_sys);
      t = 1'b0;
    end
    repeat (2) @(negedge clk_sys);
  endtask : ticks
  // pointer write, block store, pointer reuse on read
  task automatic spi_frames();
    #37;
    send(32'h5410a53c, 4);
    host_addr = 8'h10;
    repeat (2) @(negedge clk_sys);
    check(host_rdata, 16'h00a5);
    host_addr = 8'h11;
    repeat (2) @(negedge clk_sys);
    check(host_rdata, 16'h003c);
    send(32'h54100000, 2);
    send(32'h55ffff00, 3);
    check(r_all[15:0], 16'ha53c);
  endtask : spi_frames
  // service pin, io timer with compare toggle, global flags
  task automatic pins_timers();
    service_req = 1'b1;
    repeat (2) @(negedge clk_sys);
    check({dedicated_io_pins_oe[7], dedicated_io_pins_out[7]}, 16'h0003);
    compare0 = 16'h0003;
    compare_en = 2'b01;
    ticks(5, io_tick_64fs);
    check(io_timer, 16'h0005);
    check(compare_toggle_pins_out, 16'h0001);
    ticks(8, fs8_tick);
    check(gt_flags, 16'h000f);
  endtask : pins_timers
  // mailbox store, pin interrupt with capture, debug frame end
  task automatic mbx_irq();
    {mbx_valid, mbx_first, mbx_byte, debug_port_en} = {2'b11, 8'h20, 1'b1};
    @(negedge clk_sys);
    {mbx_first, mbx_byte} = {1'b0, 8'h77};
    @(negedge clk_sys);
    {mbx_valid, host_addr, gpio_irq_en} = {1'b0, 8'h20, 4'h1};
    {interrupt_pins, debug_shared_pins_in} = {4'h1, 3'h4};
    repeat (5) @(negedge clk_sys);
    check(host_rdata, 16'h0077);
    check(gpio_irq, 16'h0001);
    check(capture0, 16'h0005);
    check(debug_irq, 16'h0001);
  endtask : mbx_irq
  // main sequence
  initial begin
    {rst_n, ce, dbg_dev_addr, debug_port_en, debug_shared_pins_in, debug_io_out, debug_io_oe,
     dedicated_io_pins_in, host_io_out, host_io_oe, service_req, sp_sel, sp0_out, sp0_oe,
     sp1_out, sp1_oe, interrupt_pins, gpio_irq_en, gpio_irq_clr, io_tick_64fs, compare0,
     compare1, compare_en, fs8_tick, gt_interval, gt_flags_clr, mbx_valid, mbx_first, mbx_byte,
     host_wr, host_addr, host_wdata, debug_irq_clr, boot_vector_select_pin} = '0;
    ctl_fmt = ctl_pkg::FMT_VENDOR;
    dbg_fmt = ctl_pkg::FMT_VENDOR;
    ctl_dev_addr = 7'h2a;
    ce = 1'b1;
    repeat (3) @(negedge clk_sys);
    rst_n = 1'b1;
    repeat (2) @(negedge clk_sys);
    spi_frames();
    pins_timers();
    mbx_irq();
    stop_test();
  end
endmodule : control_bus_peripherals_bench
